// ===== hw/serial_load_pkg.sv
// Constants shared by the serial front end and its edge sampler.
// Assumes one system clock, mclk at 250 MHz, and a link clock from a pin.
`default_nettype none
package serial_load_pkg;
    localparam int CLK_PERIOD_PS   = 4000;      // mclk period
    localparam int FRAME_BITS      = 24;        // Plain write frame
    localparam int FRAME_BITS_CHK  = 32;        // Frame with check byte
    localparam int CNT_W           = 6;
    localparam int CHANNELS        = 4;
    localparam int DATA_W          = 16;
    localparam int ADDR_W          = 3;
    // Frame field positions, counted in the 24-bit payload
    localparam int READ_BIT        = 23;
    localparam int ADDR_MSB        = 22;
    localparam int ADDR_LSB        = 20;
    localparam int DATA_MSB        = 15;
    localparam int DEV_ADDR_MSB    = 19;
    localparam int DEV_ADDR_LSB    = 18;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RESET  = 6'h00;
endpackage
`default_nettype wire

// ===== hw/link_sampler_if.sv
// Interface between the main serial block and its pin sampler.
// Assumes both ends run on mclk.
`default_nettype none
interface link_sampler_if;
    logic sclk_fall;    // Falling link clock edge seen
    logic sclk_rise;    // Rising link clock edge seen
    logic frame_sel;    // Synchronised frame-select, active high
    logic frame_start;  // Frame-select just went low
    logic frame_end;    // Frame-select just went high
    logic data_bit;     // Synchronised serial input
    logic load_fall;    // Load strobe falling edge
    logic load_low;     // Synchronised load strobe is low
    logic clear;        // Synchronised clear level
    modport sampler (output sclk_fall, sclk_rise, frame_sel, frame_start,
                     frame_end, data_bit, load_fall, load_low, clear);
    modport core    (input sclk_fall, sclk_rise, frame_sel, frame_start,
                     frame_end, data_bit, load_fall, load_low, clear);
endinterface
`default_nettype wire

// ===== hw/link_sampler.sv
// Two-stage synchronisers and edge finders for the serial pins.
// Assumes every pin is asynchronous to mclk.
`default_nettype none
module link_sampler
    import serial_load_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Pins
    input  wire logic sclk,
    input  wire logic frame_sel_n,
    input  wire logic serial_in,
    input  wire logic load_strobe_n,
    input  wire logic clear,
    // Towards the core
    link_sampler_if.sampler lnk
);
    localparam int NPIN = 5;
    wire  [NPIN-1:0] pins = {clear, load_strobe_n, serial_in,
                             frame_sel_n, sclk};
    logic [NPIN-1:0] meta;
    logic [NPIN-1:0] sync;
    logic [NPIN-1:0] prev;

    // First stage feeds only the second; edges come from later stages.
    // Reset to the idle pin levels (link clock, select, data and strobe
    // high, clear low) so no false edge or clear follows reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta <= 5'h0F;
            sync <= 5'h0F;
            prev <= 5'h0F;
        end else begin
            meta <= pins;
            sync <= meta;
            prev <= sync;
        end
    end

    assign lnk.sclk_fall   = prev[0] & ~sync[0];
    assign lnk.sclk_rise   = ~prev[0] & sync[0];
    assign lnk.frame_sel   = ~sync[1];
    assign lnk.frame_start = prev[1] & ~sync[1];
    assign lnk.frame_end   = ~prev[1] & sync[1];
    assign lnk.data_bit    = sync[2];
    assign lnk.load_fall   = prev[3] & ~sync[3];
    assign lnk.load_low    = ~sync[3];
    assign lnk.clear       = sync[4];
endmodule
`default_nettype wire

// ===== hw/serial_frame_and_dac_load.sv
// Serial frame receiver with staged and direct output loading.
// Assumes a host drives frame-select, link clock, data and load strobe;
// all pins are sampled by mclk, which must run far above the link rate.
`default_nettype none
// Notes on behaviour
// - Input bits shift in on falling link clock while frame-select low.
// - In readback mode addressed output register contents shift out, one bit per clock.
// - Load strobe held low: addressed output updates at frame-select rise.
// - Load strobe high in frame: stage only; falling strobe loads all.
// - Two board address inputs select this device on a shared bus.
// - While clear is active, output register writes are blocked.
module serial_frame_and_dac_load
    import serial_load_pkg::*;
#(
    parameter int NCH = CHANNELS,
    parameter int DW  = DATA_W
)(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst_n,
    // Serial link pins
    input  wire logic                sclk,
    input  wire logic                frame_sel_n,
    input  wire logic                serial_in,
    output logic                     serial_out,
    output logic                     serial_out_oe_n,
    // Load and clear
    input  wire logic                load_strobe_n,
    input  wire logic                clear,
    // Board address straps
    input  wire logic                board_addr_bit0,
    input  wire logic                board_addr_bit1,
    // Output and stage register contents, one word per channel; frame error flag
    output logic [NCH-1:0][DW-1:0]   dac_out,
    output logic [NCH-1:0][DW-1:0]   dac_stage,
    output logic                     frame_error
);
    // Every pin but the address straps reaches the core through two flops and an edge flop, so
    // the core sees each pin edge about three mclk late. All decisions
    // are taken on those delayed edges, which keeps the pins' mutual
    // order intact: select, link clock and data share one pipe depth.
    link_sampler_if lnk ();

    link_sampler u_sampler (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .sclk          (sclk),
        .frame_sel_n   (frame_sel_n),
        .serial_in     (serial_in),
        .load_strobe_n (load_strobe_n),
        .clear         (clear),
        .lnk           (lnk)
    );

    // Board address straps pass two flops like any pin
    logic [1:0] addr_meta;
    logic [1:0] addr_sync;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addr_meta <= 2'h0;
            addr_sync <= 2'h0;
        end else begin
            addr_meta <= {board_addr_bit1, board_addr_bit0};
            addr_sync <= addr_meta;
        end
    end

    logic [FRAME_BITS_CHK-1:0] shift;
    logic [CNT_W-1:0]          bit_cnt;
    logic [DW-1:0]             read_sr;
    logic                      read_mode;
    logic [ADDR_W-1:0]         read_addr;

    // Shift register and bit count; the count restarts on each frame
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shift   <= '0;
            bit_cnt <= CNT_RESET;
        end else if (lnk.frame_start) begin
            bit_cnt <= CNT_RESET;
        end else if (lnk.frame_sel && lnk.sclk_fall) begin
            shift <= {shift[FRAME_BITS_CHK-2:0], lnk.data_bit};
            if (bit_cnt != 6'h3F)
                bit_cnt <= bit_cnt + 6'h01;
        end
    end

    // Frame length; a frame with a check byte is eight bits longer
    wire              len24;
    wire              len32;
    wire              good_len;
    assign len24    = (bit_cnt == CNT_W'(FRAME_BITS));
    assign len32    = (bit_cnt == CNT_W'(FRAME_BITS_CHK));
    assign good_len = len24 | len32;

    // With a check byte the payload sits above it; the byte is ignored
    wire [23:0]       payload;
    assign payload  = len32 ? shift[31:8] : shift[23:0];

    // Device address field against the straps
    wire [1:0]        dev_addr;
    wire              addr_ok;
    assign dev_addr = payload[DEV_ADDR_MSB:DEV_ADDR_LSB];
    assign addr_ok  = (dev_addr == addr_sync);

    // A frame acts only at its end, and only when whole and addressed;
    // a short frame leaves the stage and output registers as they were
    wire              frame_ok;
    assign frame_ok = lnk.frame_end & good_len & addr_ok;

    // Payload fields
    wire              is_read;
    wire [ADDR_W-1:0] f_addr;
    wire [DW-1:0]     f_data;
    assign is_read  = payload[READ_BIT];
    assign f_addr   = payload[ADDR_MSB:ADDR_LSB];
    assign f_data   = payload[DATA_MSB:0];

    // Load controls: strobe low at frame end loads directly, a falling
    // strobe copies every stage; clear blocks both output paths but
    // still lets the stage take the new word
    wire              do_write;
    wire              direct;
    wire              out_wr_ok;
    wire              load_all;
    assign do_write  = frame_ok & ~is_read;
    assign direct    = lnk.load_low;
    assign out_wr_ok = ~lnk.clear;
    assign load_all  = lnk.load_fall & out_wr_ok;

    // Per-channel storage in unpacked arrays, so that each lane's
    // process owns its own element and no word has two drivers
    logic [DW-1:0] stage_q [NCH];
    logic [DW-1:0] out_q   [NCH];

    // Staging and output registers, one generate lane per channel.
    // A direct write and a strobe fall in one cycle: the new word wins,
    // as it is the later value the host asked for.
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            wire hit;
            wire hit_out;
            assign hit     = do_write & (f_addr == ADDR_W'(ch));
            assign hit_out = hit & direct & out_wr_ok;
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    stage_q[ch] <= DATA_RESET;
                    out_q[ch]   <= DATA_RESET;
                end else begin
                    if (hit)
                        stage_q[ch] <= f_data;
                    if (hit_out)
                        out_q[ch] <= f_data;
                    else if (load_all)
                        out_q[ch] <= stage_q[ch];
                end
            end
        end
    endgenerate

    // Output ports show the flops directly, one process for all words
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            dac_stage[i] = stage_q[i];
            dac_out[i]   = out_q[i];
        end
    end

    // Readback word: the channel named by the last accepted frame, read or write. Addresses
    // past the last channel read back as zero rather than wrapping.
    wire          addr_in_range;
    wire [DW-1:0] read_word;
    assign addr_in_range = (read_addr < ADDR_W'(NCH));
    assign read_word     = addr_in_range ? dac_out[read_addr[1:0]]
                                         : DATA_RESET;

    // Read state. A read frame arms the next frame; the word is loaded
    // when that frame opens and shifts on each rising link clock, so the
    // host sees a settled bit at every falling edge.
    // Limitation: near the top link rate only a few mclk separate the
    // rising and falling edges, and the sync pipe eats three of them.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            read_mode <= 1'b0;
            read_addr <= '0;
            read_sr   <= DATA_RESET;
        end else if (frame_ok) begin
            read_mode <= is_read;
            read_addr <= f_addr;
        end else if (lnk.frame_start) begin
            read_sr <= read_word;
        end else if (lnk.frame_end) begin
            read_mode <= 1'b0;
        end else if (lnk.frame_sel && lnk.sclk_rise && read_mode) begin
            read_sr <= {read_sr[DW-2:0], 1'b0};
        end
    end

    // Output driven only during a readback frame; first bit on select
    wire drive;
    assign drive = read_mode & lnk.frame_sel;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            serial_out      <= 1'b0;
            serial_out_oe_n <= 1'b1;
            frame_error     <= 1'b0;
        end else begin
            serial_out      <= read_sr[DW-1];
            serial_out_oe_n <= ~drive;
            if (lnk.frame_end)
                frame_error <= ~good_len;
        end
    end
endmodule
`default_nettype wire

// ===== dv/serial_frame_and_dac_load_chk.sv
// Port checker for the serial frame block.
// Assumes frame-select stays high until results land.
`default_nettype none
module serial_frame_and_dac_load_chk #(
    parameter int NCH = 4,
    parameter int DW  = 16
)(
    // Watched ports
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   frame_sel_n,
    input  wire logic                   load_strobe_n,
    input  wire logic                   clear,
    input  wire logic                   serial_out_oe_n,
    input  wire logic [NCH-1:0][DW-1:0] dac_out,
    input  wire logic [NCH-1:0][DW-1:0] dac_stage
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Strobe fall seen and held past the sync pipe
    sequence s_load_fall;
        $fell(load_strobe_n) && !clear ##1 !load_strobe_n [*2];
    endsequence
    property p_load_all; s_load_fall |-> ##[2:8] dac_out == dac_stage; endproperty
    a_load_all: assert property (p_load_all) else $error("load copy");
    property p_direct;
        $rose(frame_sel_n) && !load_strobe_n && !clear
            |-> ##[3:8] dac_out == dac_stage;
    endproperty
    a_direct: assert property (p_direct) else $error("direct load");
    property p_stage_quiet; $changed(dac_stage) |-> frame_sel_n; endproperty
    a_stage_quiet: assert property (p_stage_quiet) else $error("stage");
    property p_out_quiet; $changed(dac_out) |-> frame_sel_n; endproperty
    a_out_quiet: assert property (p_out_quiet) else $error("out moved");
    property p_clear_hold; clear [*6] |=> $stable(dac_out); endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("clear");
    property p_oe_frame; $fell(serial_out_oe_n) |-> !frame_sel_n; endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("oe early");
    property p_oe_idle; frame_sel_n [*8] |-> serial_out_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
endmodule
bind serial_frame_and_dac_load serial_frame_and_dac_load_chk #(.NCH(NCH),
    .DW(DW)) u_chk (.mclk, .rst_n, .frame_sel_n, .load_strobe_n, .clear,
    .serial_out_oe_n, .dac_out, .dac_stage);
`default_nettype wire

// ===== dv/host_model.sv
// Host end of the link: frames, link clock, readback capture.
// Assumes mclk at 250 MHz; link period 31 mclk, near 125 ns.
`default_nettype none
module host_model (
    // Link pins
    input  wire logic mclk,
    input  wire logic serial_out,
    output logic      sclk,
    output logic      frame_sel_n,
    output logic      serial_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Link clock stands high outside frames
    initial begin
        sclk = 1'b1;
        frame_sel_n = 1'b1;
        serial_in = 1'b0;
    end
    // n bits MSB first; rd gathers serial_out at each fall
    task automatic frame(input int n, input logic [31:0] w,
                         output logic [31:0] rd);
        rd = 32'h0;
        frame_sel_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= w[i];
            repeat (16) @(posedge mclk);
            sclk <= 1'b0;
            rd = {rd[30:0], serial_out};
            repeat (15) @(posedge mclk);
            sclk <= 1'b1;
        end
        repeat (8) @(posedge mclk);
        frame_sel_n <= 1'b1;
        serial_in <= ~serial_in; // Released line must not keep old bit
        repeat (50) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ===== dv/serial_frame_and_dac_load_tb_top.sv
// Bench: host model sends frames, an int model predicts registers.
// Assumes straps read as 2'h2 and mclk at 250 MHz.
`default_nettype none
module serial_frame_and_dac_load_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_n = 0, ld_n = 1, clr = 0, sclk, fsn, sin, sout;
    logic oe_n, ferr;
    logic [3:0][15:0] dout, dstg;
    logic [31:0] rd;
    int fails = 0, num_checks = 0, stg[4], outv[4], seed = 51;
    always #2 mclk = ~mclk;
    serial_frame_and_dac_load u_dut (.mclk, .rst_n, .sclk, .frame_sel_n(fsn),
        .serial_in(sin), .serial_out(sout), .serial_out_oe_n(oe_n),
        .load_strobe_n(ld_n), .clear(clr), .board_addr_bit0(1'b0),
        .board_addr_bit1(1'b1), .dac_out(dout), .dac_stage(dstg),
        .frame_error(ferr));
    host_model u_host (.mclk, .sclk, .frame_sel_n(fsn), .serial_in(sin),
        .serial_out(sout));
    function automatic int lfsr(int s);
        return {16'h0, s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_all();
        for (int c = 0; c < 4; c++) begin
            chk("stage", stg[c], dstg[c]);
            chk("out", outv[c], dout[c]);
        end
    endtask
    // Frame of n bits; model updates only for whole frames to our strap
    task automatic wr(int n, int r, int ch, int a, int d);
        logic [23:0] p;
        p = {r[0], ch[2:0], a[1:0], 2'h0, d[15:0]};
        u_host.frame(n, {p, 8'hA5} >> (32 - n), rd);
        if ((n == 24 || n == 32) && a == 2 && r == 0) begin
            stg[ch] = d;
            if (!ld_n && !clr) outv[ch] = d;
        end
        repeat (10) @(posedge mclk);
        chk_all();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog well past the expected 33 us of traffic
    initial begin
        #300us;
        fails++;
        close_out();
    end
    initial begin
        for (int c = 0; c < 4; c++) begin
            stg[c] = 0;
            outv[c] = 0;
        end
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk_all();
        chk("oe_n", 16'h1, {15'h0, oe_n});
        for (int c = 0; c < 4; c++) begin
            seed = lfsr(seed);
            wr(24, 0, c, 2, seed);
        end
        ld_n <= 1'b0; // strobe always driven to a level
        repeat (8) @(posedge mclk);
        for (int c = 0; c < 4; c++) outv[c] = stg[c];
        repeat (6) @(posedge mclk);
        chk_all();
        seed = lfsr(seed);
        wr(32, 0, 2, 2, seed);
        wr(24, 0, 1, 1, 16'h1234);
        wr(20, 0, 3, 2, 16'hBEEF);
        chk("err", 16'h1, {15'h0, ferr});
        wr(24, 1, 2, 2, 0);
        chk("err", 16'h0, {15'h0, ferr});
        wr(24, 1, 2, 2, 0);
        chk("read", outv[2], rd[23:8]);
        clr <= 1'b1;
        wr(24, 0, 0, 2, 16'h5A5A);
        close_out();
    end
endmodule
`default_nettype wire
